/* logic/wdt_pkg.sv */
// Shared constants, register map and types for the 16-bit watchdog timer.
package wdt_pkg;

  // ==========================================================================
  // Register map (byte addresses on the APB bus)
  // ==========================================================================
  localparam logic [31:0] WDT_RELOAD_ADDR  = 32'hffff0360;
  localparam logic [31:0] WDT_COUNT_ADDR   = 32'hffff0364;
  localparam logic [31:0] WDT_CTRL_ADDR    = 32'hffff0368;
  localparam logic [31:0] WDT_CLEAR_ADDR   = 32'hffff036c;
  localparam logic [31:0] WDT_CAPTURE_ADDR = 32'hffff0370;
  localparam logic [31:0] WDT_STATUS_ADDR  = 32'hffff0374;

  // ==========================================================================
  // Widths and reset values
  // ==========================================================================
  localparam int          WDT_CNT_W      = 16;
  localparam int          WDT_CLR_W      = 8;
  localparam int          WDT_CTRL_W     = 9;
  localparam int          WDT_STAT_W     = 3;
  localparam int          WDT_DIV_W      = 8;
  localparam logic [15:0] WDT_RELOAD_RST = 16'h03d7;
  localparam logic [15:0] WDT_COUNT_RST  = 16'h03d7;
  localparam logic [15:0] WDT_CNT_ZERO   = 16'h0000;
  localparam logic [15:0] WDT_CNT_FULL   = 16'hffff;
  localparam logic [7:0]  WDT_LFSR_RST   = 8'h00;
  localparam logic [7:0]  WDT_LFSR_TAPS  = 8'h63;
  localparam logic [7:0]  WDT_SVC_ZERO   = 8'h00;

  // ==========================================================================
  // Prescaler encodings and timing figures
  // ==========================================================================
  localparam logic [1:0] WDT_PRE_DIV1     = 2'b00;
  localparam logic [1:0] WDT_PRE_DIV16    = 2'b01;
  localparam logic [1:0] WDT_PRE_DIV256   = 2'b10;
  localparam int         WDT_DIV16_LOG    = 4;
  localparam int         WDT_DIV256_LOG   = 8;
  localparam int         WDT_OSC_HZ       = 32768;
  localparam int         WDT_MAX_TIMEOUT_S = 512;
  localparam int         WDT_MAX_TIMEOUT_CALC =
    (65536 * 256) / WDT_OSC_HZ;

  // ==========================================================================
  // Status register bit positions
  // ==========================================================================
  localparam int WDT_STAT_TIMER_IRQ = 0;
  localparam int WDT_STAT_WD_MODE   = 1;
  localparam int WDT_STAT_WD_IRQ    = 2;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic       count_up;
    logic       enable;
    logic       periodic;
    logic       wd_mode;
    logic       secure;
    logic [1:0] prescale;
    logic       irq_sel;
    logic       pd_halt;
  } wdt_ctrl_s;

  localparam wdt_ctrl_s WDT_CTRL_RST = 9'h000;

  typedef enum logic [1:0] {
    WDT_ST_NORMAL  = 2'b00,
    WDT_ST_ARMED   = 2'b01,
    WDT_ST_TRIPPED = 2'b11
  } wdt_state_e;

endpackage : wdt_pkg

/* logic/wdt_prescaler.sv */
// Prescaler that passes every 1st, 16th or 256th oscillator tick.
`timescale 1ns/1ps
module wdt_prescaler #(
  parameter int DIV_W = wdt_pkg::WDT_DIV_W
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       tick_in,
  input  wire logic       clear,
  input  wire logic [1:0] sel,
  output logic            tick_out
);
  import wdt_pkg::*;

  // ==========================================================================
  // Elaboration check
  // ==========================================================================
  if (DIV_W < WDT_DIV256_LOG) begin : g_bad_width
    $error("Prescaler counter too narrow for divide by 256.");
  end

  // ==========================================================================
  // Divider
  // ==========================================================================
  logic [DIV_W-1:0] div_reg;

  // Clearing keeps a fresh timeout from inheriting a partial prescale period.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_reg <= '0;
    else if (clear)
      div_reg <= '0;
    else if (tick_in)
      div_reg <= div_reg + 1'b1;
  end

  always_comb
  begin
    case (sel)
      WDT_PRE_DIV1:   tick_out = tick_in; // (RQ3)
      WDT_PRE_DIV16:  tick_out = tick_in && (&div_reg[WDT_DIV16_LOG-1:0]); // (RQ3)
      WDT_PRE_DIV256: tick_out = tick_in && (&div_reg[WDT_DIV256_LOG-1:0]); // (RQ7)
      default:        tick_out = tick_in;
    endcase
  end

endmodule : wdt_prescaler

/* logic/wdt_lfsr.sv */
// Galois LFSR holding the expected secure service value.
`timescale 1ns/1ps
module wdt_lfsr #(
  parameter int W = wdt_pkg::WDT_CLR_W
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         seed_load,
  input  wire logic [W-1:0] seed,
  input  wire logic         advance,
  output logic [W-1:0]      state
);
  import wdt_pkg::*;

  // ==========================================================================
  // Elaboration check
  // ==========================================================================
  if (W != WDT_CLR_W) begin : g_bad_width
    $error("The feedback taps are defined for an 8-bit register only.");
  end

  // ==========================================================================
  // Shift register
  // ==========================================================================
  logic [W-1:0] lfsr_reg;
  logic [W-1:0] lfsr_next;

  always_comb
  begin
    lfsr_next = {lfsr_reg[W-2:0], 1'b0} ^ (lfsr_reg[W-1] ? WDT_LFSR_TAPS : '0); // (RQ20)
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lfsr_reg <= WDT_LFSR_RST;
    else if (seed_load)
      lfsr_reg <= seed; // (RQ20)
    else if (advance)
      lfsr_reg <= lfsr_next; // (RQ21)
  end

  assign state = lfsr_reg;

endmodule : wdt_lfsr

/* logic/wdt_top.sv */
// APB-attached 16-bit timer with normal and watchdog modes.
//
// Contract
// (RQ1) Two modes: plain timer and watchdog, chosen by a control bit.
// (RQ2) Counter reloads on expiry and at once on any service write; here not on one-shot normal-mode expiry or a bad secure write.
// (RQ3) Normal mode is a 16-bit timer on the slow oscillator, divide 1/16/256.
// (RQ4) Normal mode captures the count when its interrupt enable bit is set.
// (RQ5) Setting control bit 5 enters watchdog mode.
// (RQ6) Watchdog mode counts down from the reload value to zero.
// (RQ7) Longest timeout is 512 s with divide by 256 and full reload.
// (RQ8) Software should program at least 30 ms to survive 20 ms erases.
// (RQ9) Expiry in watchdog mode gives a reset or interrupt, per control bit 1.
// (RQ10) Software must service before zero; a fresh period then starts.
// (RQ11) After watchdog entry, reload and control writes are blocked until power-on.
// (RQ12) Non power-on resets leave the watchdog configured and counting.
// (RQ13) Software should configure the watchdog first thing after start-up.
// (RQ14) Counting halts while the debugger holds the core.
// (RQ15) Counting continues in power-down unless control bit 0 is set.
// (RQ16) Reload and count are 16-bit unsigned; count is read-only.
// (RQ17) Service write clears timer interrupt or restarts watchdog period.
// (RQ18) Reload and count reset to 0x03d7.
// (RQ19) Control bit 1 set gives an interrupt instead of reset on expiry.
// (RQ20) Secure option needs service values following an 8-bit LFSR from a seed.
// (RQ21) Matching secure write advances LFSR; mismatch or zero resets at once.
// (RQ22) Control bits 8, 7, 6: count up, enable, periodic.
// (RQ23) Blocked writes change neither stored value nor running count.
// (RQ24) Oscillator and control events are brought safely into the counter clock.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
module wdt_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        osc_32k,
  input  wire logic        debug_halt,
  input  wire logic        periph_powerdown,
  input  wire logic        irq_capture_en,
  input  wire logic        soft_reset,
  output logic             wd_reset_out,
  output logic             wd_irq_out,
  output logic             timer_irq_out,
  output wdt_pkg::wdt_ctrl_s ctrl_out
);
  import wdt_pkg::*;

  // ==========================================================================
  // Declarations
  // ==========================================================================
  wdt_ctrl_s             ctrl_reg;
  wdt_state_e            state_reg;
  wdt_state_e            state_next;
  logic [WDT_CNT_W-1:0]  reload_reg;
  logic [WDT_CNT_W-1:0]  count_reg;
  logic [WDT_CNT_W-1:0]  count_next;
  logic [WDT_CNT_W-1:0]  capture_reg;
  logic [31:0]           prdata_reg;
  logic                  timer_irq_reg;
  logic                  wd_irq_reg;
  logic                  wd_reset_reg;
  logic                  osc_s1_reg;
  logic                  osc_s2_reg;
  logic                  osc_s3_reg;
  logic                  dbg_s1_reg;
  logic                  dbg_s2_reg;
  logic                  osc_rise;
  logic                  run;
  logic                  pre_tick;
  logic                  count_up;
  logic                  terminal;
  logic                  expire;
  logic                  setup_rd;
  logic                  wr_en;
  logic                  mapped;
  logic                  wr_reload;
  logic                  wr_ctrl;
  logic                  svc_wr;
  logic                  in_wd;
  logic                  svc_secure;
  logic                  svc_match;
  logic                  svc_bad;
  logic                  svc_reload;
  logic                  wd_expire;
  logic [WDT_CLR_W-1:0]  lfsr_state;

  // ==========================================================================
  // APB decode
  // ==========================================================================
  always_comb
  begin
    case (paddr)
      WDT_RELOAD_ADDR,
      WDT_COUNT_ADDR,
      WDT_CTRL_ADDR,
      WDT_CLEAR_ADDR,
      WDT_CAPTURE_ADDR,
      WDT_STATUS_ADDR: mapped = 1'b1;
      default:         mapped = 1'b0;
    endcase
  end

  // Read data is latched in the setup cycle so the zero-wait answer comes
  // from a flip-flop.
  assign setup_rd  = psel && !penable && !pwrite;
  assign wr_en     = psel && penable && pwrite;
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !mapped;
  assign prdata    = prdata_reg;
  assign in_wd     = ctrl_reg.wd_mode;
  assign wr_reload = wr_en && (paddr == WDT_RELOAD_ADDR) && !in_wd; // (RQ11)
  assign wr_ctrl   = wr_en && (paddr == WDT_CTRL_ADDR) && !in_wd; // (RQ11)
  assign svc_wr    = wr_en && (paddr == WDT_CLEAR_ADDR);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_reg <= 32'h0000_0000;
    else if (setup_rd)
    begin
      case (paddr)
        WDT_RELOAD_ADDR:  prdata_reg <= {16'h0000, reload_reg}; // (RQ16)
        WDT_COUNT_ADDR:   prdata_reg <= {16'h0000, count_reg}; // (RQ16)
        WDT_CTRL_ADDR:    prdata_reg <= {23'h000000, ctrl_reg};
        WDT_CAPTURE_ADDR: prdata_reg <= {16'h0000, capture_reg};
        WDT_STATUS_ADDR:  prdata_reg <= {29'h00000000, wd_irq_reg, in_wd, timer_irq_reg};
        default:          prdata_reg <= 32'h0000_0000; // (RQ21)
      endcase
    end
  end

  // ==========================================================================
  // Configuration registers
  // ==========================================================================
  // Only presetn, the power-on reset, clears these; soft_reset never does.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      reload_reg <= WDT_RELOAD_RST; // (RQ18)
    else if (wr_reload) // (RQ23)
      reload_reg <= pwdata[WDT_CNT_W-1:0]; // (RQ16)
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_reg <= WDT_CTRL_RST;
    else if (wr_ctrl)
      ctrl_reg <= wdt_ctrl_s'(pwdata[WDT_CTRL_W-1:0]); // (RQ5)
  end

  assign ctrl_out = ctrl_reg;

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
      osc_s3_reg <= 1'b0;
      dbg_s1_reg <= 1'b0;
      dbg_s2_reg <= 1'b0;
    end
    else
    begin
      osc_s1_reg <= osc_32k; // (RQ24)
      osc_s2_reg <= osc_s1_reg;
      osc_s3_reg <= osc_s2_reg;
      dbg_s1_reg <= debug_halt; // (RQ24)
      dbg_s2_reg <= dbg_s1_reg;
    end
  end

  assign osc_rise = osc_s2_reg && !osc_s3_reg;

  // ==========================================================================
  // Tick generation
  // ==========================================================================
  // Watchdog mode counts whether or not the timer enable bit is set.
  assign run = (ctrl_reg.enable || in_wd) // (RQ22)
            && !dbg_s2_reg // (RQ14)
            && !(ctrl_reg.pd_halt && periph_powerdown); // (RQ15)

  wdt_prescaler #(
    .DIV_W (WDT_DIV_W)
  ) u_prescaler (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick_in  (osc_rise && run),
    .clear    (svc_reload),
    .sel      (ctrl_reg.prescale),
    .tick_out (pre_tick)
  );

  // ==========================================================================
  // Secure service sequence
  // ==========================================================================
  wdt_lfsr #(
    .W (WDT_CLR_W)
  ) u_lfsr (
    .pclk      (pclk),
    .presetn   (presetn),
    .seed_load (svc_wr && !in_wd), // (RQ20)
    .seed      (pwdata[WDT_CLR_W-1:0]),
    .advance   (svc_reload && svc_secure), // (RQ21)
    .state     (lfsr_state)
  );

  assign svc_secure = in_wd && ctrl_reg.secure;
  assign svc_match  = (pwdata[WDT_CLR_W-1:0] == lfsr_state)
                   && (pwdata[WDT_CLR_W-1:0] != WDT_SVC_ZERO); // (RQ21)
  assign svc_bad    = svc_wr && svc_secure && !svc_match; // (RQ21)
  assign svc_reload = svc_wr && !svc_bad; // (RQ2)

  // ==========================================================================
  // Counter
  // ==========================================================================
  assign count_up  = ctrl_reg.count_up && !in_wd; // (RQ6)
  assign terminal  = count_up ? (count_reg == WDT_CNT_FULL) : (count_reg == WDT_CNT_ZERO);
  assign expire    = pre_tick && terminal;
  assign wd_expire = expire && in_wd; // (RQ9)

  always_comb
  begin
    count_next = count_reg;
    if (svc_reload)
      count_next = reload_reg; // (RQ10)
    else if (expire && (ctrl_reg.periodic || in_wd))
      count_next = reload_reg; // (RQ2)
    else if (pre_tick && count_up)
      count_next = count_reg + 16'h0001; // (RQ22)
    else if (pre_tick)
      count_next = count_reg - 16'h0001; // (RQ3)
  end

  // The count survives soft_reset so a watchdog reset does not restart it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_reg <= WDT_COUNT_RST; // (RQ18)
    else
      count_reg <= count_next; // (RQ12)
  end

  // ==========================================================================
  // Normal mode interrupt and capture
  // ==========================================================================
  // A new event in the same cycle as its clear keeps the flag set.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timer_irq_reg <= 1'b0;
    else
      timer_irq_reg <= (expire && !in_wd)
                    || (timer_irq_reg && !svc_wr && !soft_reset); // (RQ17)
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      capture_reg <= 16'h0000;
    else if (expire && !in_wd && irq_capture_en)
      capture_reg <= count_reg; // (RQ4)
  end

  assign timer_irq_out = timer_irq_reg;

  // ==========================================================================
  // Watchdog state machine
  // ==========================================================================
  always_comb
  begin
    case (state_reg)
      WDT_ST_NORMAL:
        state_next = in_wd ? WDT_ST_ARMED : WDT_ST_NORMAL; // (RQ1)
      WDT_ST_ARMED:
        if (svc_bad || (wd_expire && !ctrl_reg.irq_sel && !svc_reload))
          state_next = WDT_ST_TRIPPED; // (RQ9)
        else
          state_next = WDT_ST_ARMED;
      WDT_ST_TRIPPED:
        state_next = WDT_ST_ARMED; // (RQ12)
      default:
        state_next = WDT_ST_NORMAL;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_reg <= WDT_ST_NORMAL;
    else
      state_reg <= state_next;
  end

  // The reset request is a single-cycle pulse; the chip reset logic stretches it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wd_reset_reg <= 1'b0;
    else
      wd_reset_reg <= (state_next == WDT_ST_TRIPPED) && (state_reg != WDT_ST_TRIPPED);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wd_irq_reg <= 1'b0;
    else
      wd_irq_reg <= (wd_expire && ctrl_reg.irq_sel && !svc_reload) // (RQ19)
                 || (wd_irq_reg && !svc_wr);
  end

  assign wd_reset_out = wd_reset_reg;
  assign wd_irq_out   = wd_irq_reg;

endmodule : wdt_top

/* verification/wdt_top_monitor.sv */
// Concurrent checks on the ports of the watchdog timer block.
`timescale 1ns/1ps
module wdt_top_monitor (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [31:0]        paddr,
  input wire logic [31:0]        pwdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic               soft_reset,
  input wire logic               wd_reset_out,
  input wire logic               wd_irq_out,
  input wire wdt_pkg::wdt_ctrl_s ctrl_out
);
  import wdt_pkg::*;
  // ==========================================================================
  // Decoded bus events
  // ==========================================================================
  logic svc_wr;
  logic ctrl_wr;
  logic mapped;
  assign svc_wr  = psel && penable && pwrite && (paddr == WDT_CLEAR_ADDR);
  assign ctrl_wr = psel && penable && pwrite && (paddr == WDT_CTRL_ADDR);
  assign mapped  = paddr inside {WDT_RELOAD_ADDR, WDT_COUNT_ADDR, WDT_CTRL_ADDR,
                                 WDT_CLEAR_ADDR, WDT_CAPTURE_ADDR, WDT_STATUS_ADDR};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================================
  // Assertions
  // ==========================================================================
  zero_wait_a: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  unmapped_err_a: assert property (psel && penable |-> pslverr == !mapped)
    else $error("error response does not match address decode");
  ctrl_copy_a: assert property (ctrl_wr && !ctrl_out.wd_mode |=> ctrl_out == $past(pwdata[8:0]))
    else $error("control copy differs from written value");
  wd_entry_a: assert property (ctrl_wr && pwdata[5] && !ctrl_out.wd_mode |=> ctrl_out.wd_mode)
    else $error("watchdog mode not entered");
  ctrl_lock_a: assert property (ctrl_out.wd_mode |=> $stable(ctrl_out))
    else $error("control changed after watchdog entry");
  soft_keep_a: assert property (soft_reset && !ctrl_wr |=> $stable(ctrl_out))
    else $error("soft reset disturbed the control setting");
  reset_pulse_a: assert property ($rose(wd_reset_out) |=> !wd_reset_out)
    else $error("reset request longer than one cycle");
  irq_route_a: assert property (wd_irq_out |-> ctrl_out.wd_mode && ctrl_out.irq_sel)
    else $error("watchdog interrupt without interrupt option");
  irq_hold_a: assert property (wd_irq_out && !svc_wr |=> wd_irq_out)
    else $error("watchdog interrupt dropped without service");
  secure_zero_a: assert property (svc_wr && ctrl_out.wd_mode && ctrl_out.secure
                                  && pwdata[7:0] == 8'h00 |-> ##[1:2] wd_reset_out)
    else $error("zero secure service did not reset");
endmodule : wdt_top_monitor

bind wdt_top wdt_top_monitor u_wdt_top_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .soft_reset(soft_reset), .wd_reset_out(wd_reset_out),
  .wd_irq_out(wd_irq_out), .ctrl_out(ctrl_out));

/* verification/wdt_top_test.sv */
// Self-checking bench for the watchdog timer block.
`timescale 1ns/1ps
module wdt_top_test;
  import wdt_pkg::*;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        osc_32k = 1'b0;
  logic        debug_halt = 1'b0;
  logic        periph_powerdown = 1'b0;
  logic        irq_capture_en = 1'b1;
  logic        soft_reset = 1'b0;
  logic        wd_reset_out;
  logic        wd_irq_out;
  logic        timer_irq_out;
  wdt_ctrl_s   ctrl_out;
  int          n_fail = 0;
  int          n_checks = 0;
  int          n_rst = 0;

  always #4 pclk = ~pclk;
  // Reset requests are one cycle long, so they are counted rather than polled.
  always @(posedge pclk) if (wd_reset_out === 1'b1) n_rst <= n_rst + 1;

  wdt_top u_wdt_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .osc_32k(osc_32k), .debug_halt(debug_halt),
    .periph_powerdown(periph_powerdown), .irq_capture_en(irq_capture_en),
    .soft_reset(soft_reset), .wd_reset_out(wd_reset_out), .wd_irq_out(wd_irq_out),
    .timer_irq_out(timer_irq_out), .ctrl_out(ctrl_out));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic stop_test();
    if (n_fail == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      n_fail++;
    end
  endtask : chk

  task automatic apb(input logic [31:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(a, 1'b1, d, r, e);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
    logic [31:0] r;
    logic        e;
    apb(a, 1'b0, 32'h0, r, e);
    chk(r, exp, what);
  endtask : rd

  // Half periods of four cycles keep each oscillator level above the sync depth.
  task automatic ticks(input int n);
    repeat (n)
    begin
      repeat (4) @(posedge pclk);
      osc_32k <= 1'b1;
      repeat (4) @(posedge pclk);
      osc_32k <= 1'b0;
    end
    repeat (6) @(posedge pclk);
  endtask : ticks

  task automatic por();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
  endtask : por

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_normal();
    logic [31:0] r;
    logic        e;
    rd(WDT_RELOAD_ADDR, 32'h03d7, "reload reset");
    rd(WDT_COUNT_ADDR, 32'h03d7, "count reset");
    apb(32'hffff0378, 1'b0, 32'h0, r, e);
    chk(32'(e), 32'h1, "unmapped error");
    wr(WDT_RELOAD_ADDR, 32'h5);
    wr(WDT_CTRL_ADDR, 32'h0c0);
    @(posedge pclk);
    chk(32'(ctrl_out), 32'h0c0, "control copy");
    wr(WDT_CLEAR_ADDR, 32'h0);
    wr(WDT_COUNT_ADDR, 32'h1234);
    rd(WDT_COUNT_ADDR, 32'h5, "reload on service, count read-only");
    ticks(3);
    rd(WDT_COUNT_ADDR, 32'h2, "count down by one");
    ticks(3);
    chk(32'(timer_irq_out), 32'h1, "timer expiry flag");
    rd(WDT_STATUS_ADDR, 32'h1, "status flag");
    rd(WDT_COUNT_ADDR, 32'h5, "reload on expiry");
    wr(WDT_CLEAR_ADDR, 32'h0);
    @(posedge pclk);
    chk(32'(timer_irq_out), 32'h0, "service clears flag");
    wr(WDT_CTRL_ADDR, 32'h0c4);
    wr(WDT_CLEAR_ADDR, 32'h0);
    ticks(15);
    rd(WDT_COUNT_ADDR, 32'h5, "divide by 16 holds");
    ticks(1);
    rd(WDT_COUNT_ADDR, 32'h4, "divide by 16 steps");
    wr(WDT_CTRL_ADDR, 32'h1c0);
    wr(WDT_CLEAR_ADDR, 32'h0);
    ticks(1);
    rd(WDT_COUNT_ADDR, 32'h6, "count up");
    debug_halt <= 1'b1;
    ticks(2);
    rd(WDT_COUNT_ADDR, 32'h6, "debug halt");
    debug_halt       <= 1'b0;
    periph_powerdown <= 1'b1;
    ticks(1);
    rd(WDT_COUNT_ADDR, 32'h7, "counts in power-down");
    wr(WDT_CTRL_ADDR, 32'h1c1);
    ticks(1);
    rd(WDT_COUNT_ADDR, 32'h7, "power-down halt");
    periph_powerdown <= 1'b0;
  endtask : t_normal

  task automatic t_wd_irq();
    int base;
    base = n_rst;
    por();
    wr(WDT_RELOAD_ADDR, 32'h3);
    wr(WDT_CTRL_ADDR, 32'h022);
    @(posedge pclk);
    chk(32'(ctrl_out), 32'h022, "watchdog entry");
    wr(WDT_CTRL_ADDR, 32'h0);
    wr(WDT_RELOAD_ADDR, 32'h100);
    chk(32'(ctrl_out), 32'h022, "control locked");
    rd(WDT_RELOAD_ADDR, 32'h3, "reload locked");
    wr(WDT_CLEAR_ADDR, 32'h5a);
    ticks(3);
    rd(WDT_COUNT_ADDR, 32'h0, "watchdog counts to zero");
    chk(32'(wd_irq_out), 32'h0, "no interrupt before expiry");
    ticks(1);
    chk(32'(wd_irq_out), 32'h1, "interrupt on expiry");
    chk(n_rst - base, 32'h0, "no reset with interrupt option");
    wr(WDT_CLEAR_ADDR, 32'h0);
    @(posedge pclk);
    chk(32'(wd_irq_out), 32'h0, "service clears interrupt");
  endtask : t_wd_irq

  task automatic t_wd_reset();
    int base;
    base = n_rst;
    por();
    wr(WDT_RELOAD_ADDR, 32'h2);
    wr(WDT_CTRL_ADDR, 32'h020);
    wr(WDT_CLEAR_ADDR, 32'h0);
    ticks(2);
    wr(WDT_CLEAR_ADDR, 32'h0);
    ticks(2);
    chk(n_rst - base, 32'h0, "service in time");
    ticks(1);
    chk(n_rst - base, 32'h1, "reset on expiry");
    soft_reset <= 1'b1;
    @(posedge pclk);
    soft_reset <= 1'b0;
    ticks(1);
    chk(32'(ctrl_out), 32'h020, "soft reset keeps mode");
    rd(WDT_COUNT_ADDR, 32'h1, "soft reset keeps counting");
  endtask : t_wd_reset

  task automatic t_secure();
    int base;
    base = n_rst;
    por();
    wr(WDT_RELOAD_ADDR, 32'h10);
    wr(WDT_CLEAR_ADDR, 32'haa);
    wr(WDT_CTRL_ADDR, 32'h030);
    wr(WDT_CLEAR_ADDR, 32'haa);
    wr(WDT_CLEAR_ADDR, 32'h37);
    ticks(1);
    wr(WDT_CLEAR_ADDR, 32'h6e);
    repeat (2) @(posedge pclk);
    chk(n_rst - base, 32'h0, "matching sequence");
    rd(WDT_COUNT_ADDR, 32'h10, "secure reload");
    wr(WDT_CLEAR_ADDR, 32'h66);
    repeat (2) @(posedge pclk);
    chk(n_rst - base, 32'h1, "mismatch resets");
    wr(WDT_CLEAR_ADDR, 32'h0);
    repeat (2) @(posedge pclk);
    chk(n_rst - base, 32'h2, "zero resets");
  endtask : t_secure

  // ==========================================================================
  // Main sequence and watchdog
  // ==========================================================================
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_normal();
    t_wd_irq();
    t_wd_reset();
    t_secure();
    stop_test();
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    $display("unexpected at %0t: run did not finish", $time);
    n_fail++;
    stop_test();
  end
endmodule : wdt_top_test
